// ==== hw/lsf_pkg.sv ====
// Purpose: constants for the LIN status flag register bank
// Assumes: 40 MHz system clock, AHB-Lite register access
// Notes: registers are indexed; byte address is four times the index
package lsf_pkg;
   // Register indices, as printed
   localparam logic [7:0] LSF_IDX_CONTROL = 8'h08;
   localparam logic [7:0] LSF_IDX_STATUS = 8'h09;
   localparam logic [7:0] LSF_IDX_ERROR = 8'h0a;
   localparam logic [7:0] LSF_IDX_IRQ_STAT = 8'h10;
   localparam logic [7:0] LSF_IDX_IRQ_MASK = 8'h11;
   localparam logic [7:0] LSF_IDX_MODE = 8'h12;
   // Status bit positions
   localparam int LSF_ST_ACTIVE = 7;
   localparam int LSF_ST_IDLE = 6;
   localparam int LSF_ST_ABORT = 5;
   localparam int LSF_ST_DREQ = 4;
   localparam int LSF_ST_INT = 3;
   localparam int LSF_ST_ERR = 2;
   localparam int LSF_ST_WAKE = 1;
   localparam int LSF_ST_DONE = 0;
   // Control bit positions
   localparam int LSF_CT_STOP = 7;
   localparam int LSF_CT_CLR_INT = 3;
   localparam int LSF_CT_CLR_ERR = 2;
   // Reset values
   localparam logic [7:0] LSF_STATUS_RST = 8'h00;
   localparam logic [4:0] LSF_ERROR_RST = 5'h00;
   // Timing
   localparam longint LSF_CLK_HZ = 40000000;
   localparam longint LSF_IDLE_TIME_S = 4;
   localparam longint LSF_IDLE_CYCLES = LSF_IDLE_TIME_S * LSF_CLK_HZ;
endpackage : lsf_pkg

// ==== hw/lsf_sync.sv ====
// Purpose: two flip-flop synchroniser for pin level inputs
// Assumes: inputs asynchronous to sys_clk
// Notes: first stage feeds only the second stage
`timescale 1ns/1ps
module lsf_sync #(
   parameter int WIDTH = 8
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Data
   input wire logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] dout
);
   logic [WIDTH-1:0] meta_q;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta_q <= '0;
         dout <= '0;
      end else begin
         meta_q <= din;
         dout <= meta_q;
      end
   end
endmodule : lsf_sync

// ==== hw/lsf_idle_timer.sv ====
// Purpose: bus idle timer, flags after a long quiet period
// Assumes: count length given by parameter
// Notes: restarts on any activity, holds at the limit
`timescale 1ns/1ps
module lsf_idle_timer #(
   parameter longint LIMIT = 160000000
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Control
   input wire logic enable,
   input wire logic restart,
   // Result
   output logic expired
);
   logic [31:0] count_q;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         count_q <= 32'h0000_0000;
         expired <= 1'b0;
      end else if (restart || !enable) begin
         count_q <= 32'h0000_0000;
         expired <= 1'b0;
      end else if (count_q >= 32'(LIMIT - 1)) begin
         expired <= 1'b1;
      end else begin
         count_q <= count_q + 32'h0000_0001;
      end
   end
endmodule : lsf_idle_timer

// ==== hw/lsf_status_regs.sv ====
// Purpose: LIN controller status flags with AHB-Lite register access
// Assumes: controller events arrive as pins, synchronised here
// Notes: status register is read only; clears go through control bits
// Notes on behaviour
// - Active bit follows bus activity
// - Slave idle four seconds, not asleep, sets timeout
// - Slave abort on early break or stop
// - Clean sync break clears abort
// - Slave data request set on identifier
// - Interrupt pending cleared only by clear-interrupt write
// - Error sticky until clear-error write
// - Wakeup set while sending or after receiving
// - Done cleared at start, set at finish
// - Clear-error clears status and detail errors, reads zero
// - Stop suspends slave processing until next break
`timescale 1ns/1ps
module lsf_status_regs
   import lsf_pkg::*;
#(
   parameter longint IDLE_CYCLES = LSF_IDLE_CYCLES
) (
   // System
   input wire logic SYS_CLK,
   input wire logic RST,
   // AHB-Lite slave
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic HREADY,
   input wire logic [31:0] HWDATA,
   output logic [31:0] HRDATA,
   output logic HREADYOUT,
   output logic HRESP,
   // Controller events from the LIN engine
   input wire logic BUS_ACTIVITY,
   input wire logic SLAVE_MODE,
   input wire logic BUS_ASLEEP,
   input wire logic SYNC_BREAK,
   input wire logic XFER_START,
   input wire logic XFER_END,
   input wire logic ID_RECEIVED,
   input wire logic DATA_ACKED,
   input wire logic CTRL_IRQ,
   input wire logic [4:0] ERR_EVENTS,
   input wire logic WAKE_SENDING,
   input wire logic WAKE_RECEIVED,
   // Outputs
   output logic PROCESSING_STOPPED,
   output logic IRQ
);
   ////////////////////////////////////////////////////////////////////////////
   // Input synchronisation
   logic [11:0] pins_raw;
   logic [11:0] pins_s;
   logic [4:0] err_s;
   logic act_s, slave_s, asleep_s, brk_s, start_s, end_s;
   logic id_s, ack_s, irq_s, wsend_s, wrecv_s;

   assign pins_raw = {BUS_ACTIVITY, SLAVE_MODE, BUS_ASLEEP, SYNC_BREAK, XFER_START,
                      XFER_END, ID_RECEIVED, DATA_ACKED, CTRL_IRQ, WAKE_SENDING,
                      WAKE_RECEIVED, 1'b0};

   lsf_sync #(.WIDTH(12)) u_sync_pins (
      .clk(SYS_CLK),
      .rst(RST),
      .din(pins_raw),
      .dout(pins_s)
   );

   lsf_sync #(.WIDTH(5)) u_sync_err (
      .clk(SYS_CLK),
      .rst(RST),
      .din(ERR_EVENTS),
      .dout(err_s)
   );

   assign {act_s, slave_s, asleep_s, brk_s, start_s, end_s, id_s, ack_s, irq_s,
           wsend_s, wrecv_s} = pins_s[11:1];

   // Rising edge detectors on synchronised strobes
   logic brk_d_q, start_d_q, end_d_q, id_d_q, irq_d_q, wrecv_d_q;
   logic [4:0] err_d_q;
   logic brk_p, start_p, end_p, id_p, irq_p, wrecv_p;
   logic [4:0] err_p;

   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         brk_d_q <= 1'b0;
         start_d_q <= 1'b0;
         end_d_q <= 1'b0;
         id_d_q <= 1'b0;
         irq_d_q <= 1'b0;
         wrecv_d_q <= 1'b0;
         err_d_q <= 5'h00;
      end else begin
         brk_d_q <= brk_s;
         start_d_q <= start_s;
         end_d_q <= end_s;
         id_d_q <= id_s;
         irq_d_q <= irq_s;
         wrecv_d_q <= wrecv_s;
         err_d_q <= err_s;
      end
   end

   assign brk_p = brk_s & ~brk_d_q;
   assign start_p = start_s & ~start_d_q;
   assign end_p = end_s & ~end_d_q;
   assign id_p = id_s & ~id_d_q;
   assign irq_p = irq_s & ~irq_d_q;
   assign wrecv_p = wrecv_s & ~wrecv_d_q;
   assign err_p = err_s & ~err_d_q;

   ////////////////////////////////////////////////////////////////////////////
   // AHB-Lite address phase capture
   logic wr_pend_q;
   logic rd_pend_q;
   logic [7:0] idx_q;
   logic addr_ok;
   logic wr_stb;
   logic [7:0] wr_idx;
   logic [7:0] wr_byte;

   assign addr_ok = HSEL && HREADY && HTRANS[1];

   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         wr_pend_q <= 1'b0;
         rd_pend_q <= 1'b0;
         idx_q <= 8'h00;
      end else begin
         wr_pend_q <= addr_ok && HWRITE;
         rd_pend_q <= addr_ok && !HWRITE;
         if (addr_ok) begin
            idx_q <= HADDR[9:2];
         end
      end
   end

   assign wr_stb = wr_pend_q;
   assign wr_idx = idx_q;
   assign wr_byte = HWDATA[7:0];

   function automatic logic wr_bit(input logic [7:0] idx, input int pos);
      wr_bit = wr_stb && (wr_idx == idx) && wr_byte[pos];
   endfunction : wr_bit

   ////////////////////////////////////////////////////////////////////////////
   // Control strobes and mode register
   logic clr_int, clr_err, stop_wr;
   logic stop_q;
   logic in_transfer_q;

   assign clr_int = wr_bit(LSF_IDX_CONTROL, LSF_CT_CLR_INT);
   assign clr_err = wr_bit(LSF_IDX_CONTROL, LSF_CT_CLR_ERR);
   assign stop_wr = wr_bit(LSF_IDX_CONTROL, LSF_CT_STOP) && slave_s;

   // Suspend until the next sync break
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         stop_q <= 1'b0;
      end else if (brk_p) begin
         stop_q <= 1'b0;
      end else if (stop_wr) begin
         stop_q <= 1'b1;
      end
   end

   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         PROCESSING_STOPPED <= 1'b0;
      end else begin
         PROCESSING_STOPPED <= (stop_q && !brk_p) || stop_wr;
      end
   end

   // Transfer tracking
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         in_transfer_q <= 1'b0;
      end else if (start_p || brk_p) begin
         in_transfer_q <= 1'b1;
      end else if (end_p) begin
         in_transfer_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Status flags
   logic idle_exp;
   logic [7:0] status_q;
   logic [4:0] err_detail_q;

   lsf_idle_timer #(.LIMIT(IDLE_CYCLES)) u_idle (
      .clk(SYS_CLK),
      .rst(RST),
      .enable(slave_s && !asleep_s),
      .restart(act_s),
      .expired(idle_exp)
   );

   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         status_q[LSF_ST_ACTIVE] <= 1'b0;
         status_q[LSF_ST_IDLE] <= 1'b0;
         status_q[LSF_ST_WAKE] <= 1'b0;
      end else begin
         status_q[LSF_ST_ACTIVE] <= act_s;
         status_q[LSF_ST_IDLE] <= idle_exp && slave_s && !asleep_s;
         if (wsend_s || wrecv_p) begin
            status_q[LSF_ST_WAKE] <= 1'b1;
         end else if (act_s && !wsend_s) begin
            status_q[LSF_ST_WAKE] <= 1'b0;
         end
      end
   end

   // Abort: early break or stop in slave mode
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         status_q[LSF_ST_ABORT] <= 1'b0;
      end else if (slave_s && ((brk_p && in_transfer_q) || stop_wr)) begin
         status_q[LSF_ST_ABORT] <= 1'b1;
      end else if (brk_p && !in_transfer_q) begin
         status_q[LSF_ST_ABORT] <= 1'b0;
      end
   end

   // Data request: identifier seen, dropped by ack, break or stop
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         status_q[LSF_ST_DREQ] <= 1'b0;
      end else if (!slave_s) begin
         status_q[LSF_ST_DREQ] <= 1'b0;
      end else if (id_p && !stop_q) begin
         status_q[LSF_ST_DREQ] <= 1'b1;
      end else if (ack_s || brk_p || stop_wr) begin
         status_q[LSF_ST_DREQ] <= 1'b0;
      end
   end

   // Interrupt pending: set wins over clear
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         status_q[LSF_ST_INT] <= 1'b0;
      end else if (irq_p) begin
         status_q[LSF_ST_INT] <= 1'b1;
      end else if (clr_int) begin
         status_q[LSF_ST_INT] <= 1'b0;
      end
   end

   // Error summary and detail, both cleared by the clear-error control
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         status_q[LSF_ST_ERR] <= 1'b0;
         err_detail_q <= LSF_ERROR_RST;
      end else begin
         if (|err_p) begin
            status_q[LSF_ST_ERR] <= 1'b1;
         end else if (clr_err) begin
            status_q[LSF_ST_ERR] <= 1'b0;
         end
         err_detail_q <= (clr_err ? LSF_ERROR_RST : err_detail_q) | err_p;
      end
   end

   // Done: cleared at start, set at end
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         status_q[LSF_ST_DONE] <= 1'b0;
      end else if (end_p) begin
         status_q[LSF_ST_DONE] <= 1'b1;
      end else if (start_p || brk_p) begin
         status_q[LSF_ST_DONE] <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt status, write one to clear, and mask
   logic [7:0] irq_stat_q;
   logic [7:0] irq_mask_q;
   logic [7:0] status_prev_q;
   logic [7:0] rise;

   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         status_prev_q <= LSF_STATUS_RST;
      end else begin
         status_prev_q <= status_q;
      end
   end

   assign rise = status_q & ~status_prev_q;

   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         irq_stat_q <= 8'h00;
      end else if (wr_stb && wr_idx == LSF_IDX_IRQ_STAT) begin
         irq_stat_q <= (irq_stat_q & ~wr_byte) | rise;
      end else begin
         irq_stat_q <= irq_stat_q | rise;
      end
   end

   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         irq_mask_q <= 8'h00;
      end else if (wr_stb && wr_idx == LSF_IDX_IRQ_MASK) begin
         irq_mask_q <= wr_byte;
      end
   end

   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         IRQ <= 1'b0;
      end else begin
         IRQ <= |(irq_stat_q & irq_mask_q);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read data; status writes are ignored, control reads as zero
   logic [7:0] rd_byte;

   always_comb begin
      case (idx_q)
         LSF_IDX_CONTROL: rd_byte = 8'h00;
         LSF_IDX_STATUS: rd_byte = status_q;
         LSF_IDX_ERROR: rd_byte = {3'h0, err_detail_q};
         LSF_IDX_IRQ_STAT: rd_byte = irq_stat_q;
         LSF_IDX_IRQ_MASK: rd_byte = irq_mask_q;
         LSF_IDX_MODE: rd_byte = {6'h00, PROCESSING_STOPPED, slave_s};
         default: rd_byte = 8'h00;
      endcase
   end

   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         HRDATA <= 32'h0000_0000;
      end else if (addr_ok && !HWRITE) begin
         HRDATA <= 32'h0000_0000;
      end else if (rd_pend_q) begin
         HRDATA <= {24'h00_0000, rd_byte};
      end
   end

   // Reads take one wait state so the data leave a flip-flop
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         HREADYOUT <= 1'b1;
      end else begin
         HREADYOUT <= !(addr_ok && !HWRITE);
      end
   end

   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         HRESP <= 1'b0;
      end else begin
         HRESP <= 1'b0;
      end
   end
endmodule : lsf_status_regs

// ==== verif/lsf_status_assertions.sv ====
// Purpose: port checker for the LIN status flag register bank
// Assumes: the bench ties HREADY to HREADYOUT
// Notes: pin events reach the flags after about three cycles
`timescale 1ns/1ps
module lsf_status_assertions
   import lsf_pkg::*;
(
   // System
   input wire logic SYS_CLK,
   input wire logic RST,
   // Bus
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic HREADY,
   input wire logic [31:0] HWDATA,
   input wire logic [31:0] HRDATA,
   input wire logic HREADYOUT,
   input wire logic HRESP,
   // Controller
   input wire logic SLAVE_MODE,
   input wire logic SYNC_BREAK,
   input wire logic PROCESSING_STOPPED
);
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (RST);
   logic take;
   logic rd;
   logic wr_ctl;
   assign take = HSEL && HREADY && HTRANS[1];
   assign rd = take && !HWRITE;
   assign wr_ctl = take && HWRITE && (HADDR[9:2] == LSF_IDX_CONTROL);
   a_read_wait: assert property (rd |=> !HREADYOUT ##1 HREADYOUT)
      else $error("read wait state missing");
   a_write_ready: assert property (take && HWRITE |=> HREADYOUT)
      else $error("write stalled");
   a_ready_pulse: assert property (!HREADYOUT |=> HREADYOUT)
      else $error("wait state too long");
   a_resp_okay: assert property (!HRESP)
      else $error("error response seen");
   a_rdata_upper: assert property (HRDATA[31:8] == 24'h0)
      else $error("upper read data set");
   a_rdata_hold: assert property ($changed(HRDATA) |-> $past(rd) || $past(rd, 2))
      else $error("read data changed without read");
   a_stop_cause: assert property ($rose(PROCESSING_STOPPED) |->
      $past(wr_ctl, 2) && $past(HWDATA[LSF_CT_STOP]) && SLAVE_MODE)
      else $error("stop without control write");
   a_stop_hold: assert property (PROCESSING_STOPPED && SLAVE_MODE && !SYNC_BREAK
      && !$past(SYNC_BREAK) && !$past(SYNC_BREAK, 2) && !$past(SYNC_BREAK, 3)
      && !$past(SYNC_BREAK, 4) |=> PROCESSING_STOPPED)
      else $error("stop released without break");
endmodule : lsf_status_assertions

// ==== verif/lsf_lin_node.sv ====
// Purpose: model of the other LIN nodes and the frame engine events
// Assumes: each event is three cycles high, then three low
// Notes: bus activity is a level held until changed
`timescale 1ns/1ps
module lsf_lin_node (
   // Clock
   input wire logic clk,
   // Bus events
   output logic bus_act,
   output logic brk,
   output logic start,
   output logic fin,
   output logic idr,
   output logic wake,
   output logic [4:0] err
);
   logic [4:0] ev = 5'h00;
   initial begin
      bus_act = 1'b0;
      err = 5'h00;
   end
   assign {wake, idr, fin, start, brk} = ev;
   task automatic act(input logic v);
      @(posedge clk);
      bus_act <= v;
   endtask : act
   // Breaks, frame edges and error events as the bus would show them
   task automatic pulse(input logic [4:0] e, input logic [4:0] x);
      @(posedge clk);
      ev <= e;
      err <= x;
      repeat (3) @(posedge clk);
      ev <= 5'h00;
      err <= 5'h00;
      repeat (3) @(posedge clk);
   endtask : pulse
endmodule : lsf_lin_node

// ==== verif/lsf_status_regs_tb.sv ====
// Purpose: self-checking bench for the LIN status flag register bank
// Assumes: idle count shortened to fifty cycles
// Notes: status bits are checked one at a time, except in the whole-register reset check
`timescale 1ns/1ps
module lsf_status_regs_tb
   import lsf_pkg::*;
();
   localparam longint IDLE_N = 50;
   localparam logic [4:0] EV_BRK = 5'h01;
   localparam logic [4:0] EV_START = 5'h02;
   localparam logic [4:0] EV_END = 5'h04;
   localparam logic [4:0] EV_ID = 5'h08;
   localparam logic [4:0] EV_WAKE = 5'h10;
   logic SYS_CLK = 1'b0;
   logic RST = 1'b1;
   logic HSEL = 1'b0;
   logic [31:0] HADDR = 32'h0;
   logic [1:0] HTRANS = 2'h0;
   logic HWRITE = 1'b0;
   logic [31:0] HWDATA = 32'h0;
   logic [31:0] HRDATA;
   logic HREADYOUT, HRESP, PROCESSING_STOPPED, IRQ;
   logic SLAVE_MODE = 1'b0;
   logic BUS_ASLEEP = 1'b0;
   logic DATA_ACKED = 1'b0;
   logic CTRL_IRQ = 1'b0;
   logic WAKE_SENDING = 1'b0;
   logic BUS_ACTIVITY, SYNC_BREAK, XFER_START, XFER_END, ID_RECEIVED, WAKE_RECEIVED;
   logic [4:0] ERR_EVENTS;
   int err_total = 0;
   int samples_checked = 0;
   int cycles = 0;
   lsf_status_regs #(.IDLE_CYCLES(IDLE_N)) dut (.SYS_CLK(SYS_CLK), .RST(RST),
      .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2),
      .HREADY(HREADYOUT), .HWDATA(HWDATA), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
      .HRESP(HRESP), .BUS_ACTIVITY(BUS_ACTIVITY), .SLAVE_MODE(SLAVE_MODE),
      .BUS_ASLEEP(BUS_ASLEEP), .SYNC_BREAK(SYNC_BREAK), .XFER_START(XFER_START),
      .XFER_END(XFER_END), .ID_RECEIVED(ID_RECEIVED), .DATA_ACKED(DATA_ACKED),
      .CTRL_IRQ(CTRL_IRQ), .ERR_EVENTS(ERR_EVENTS), .WAKE_SENDING(WAKE_SENDING),
      .WAKE_RECEIVED(WAKE_RECEIVED), .PROCESSING_STOPPED(PROCESSING_STOPPED), .IRQ(IRQ));
   lsf_lin_node node (.clk(SYS_CLK), .bus_act(BUS_ACTIVITY), .brk(SYNC_BREAK),
      .start(XFER_START), .fin(XFER_END), .idr(ID_RECEIVED), .wake(WAKE_RECEIVED),
      .err(ERR_EVENTS));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("BAD %0t read %h expected %h", $time, got, exp);
      end
   endtask : chk_reg
   task automatic chk_pin(input logic got, input logic exp);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("BAD %0t pin %b expected %b", $time, got, exp);
      end
   endtask : chk_pin
   task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] wd,
                      output logic [31:0] rd);
      @(posedge SYS_CLK);
      HSEL <= 1'b1;
      HTRANS <= 2'h2;
      HADDR <= {22'h0, idx, 2'h0};
      HWRITE <= w;
      do @(posedge SYS_CLK); while (HREADYOUT !== 1'b1);
      HSEL <= 1'b0;
      HTRANS <= 2'h0;
      HWDATA <= wd;
      do @(posedge SYS_CLK); while (HREADYOUT !== 1'b1);
      rd = HRDATA;
   endtask : bus
   task automatic wr(input logic [7:0] idx, input logic [31:0] d);
      logic [31:0] x;
      bus(1'b1, idx, d, x);
   endtask : wr
   task automatic rdm(input logic [7:0] idx, input logic [31:0] m, input logic [31:0] e);
      logic [31:0] x;
      bus(1'b0, idx, 32'h0, x);
      chk_reg(x & m, e);
   endtask : rdm
   task automatic st_bit(input int pos, input logic e);
      rdm(LSF_IDX_STATUS, 32'h1 << pos, {31'h0, e} << pos);
   endtask : st_bit
   task automatic cyc(input int n);
      repeat (n) @(posedge SYS_CLK);
   endtask : cyc
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      rdm(LSF_IDX_STATUS, 32'hffffffff, 32'h0);
      rdm(LSF_IDX_ERROR, 32'hffffffff, 32'h0);
      rdm(8'h3f, 32'hffffffff, 32'h0);
      chk_pin(PROCESSING_STOPPED, 1'b0);
   endtask : t_reset
   task automatic t_active();
      node.act(1'b1);
      cyc(5);
      st_bit(LSF_ST_ACTIVE, 1'b1);
      node.act(1'b0);
      cyc(5);
      st_bit(LSF_ST_ACTIVE, 1'b0);
   endtask : t_active
   task automatic t_idle();
      cyc(int'(IDLE_N) + 20);
      st_bit(LSF_ST_IDLE, 1'b0);
      SLAVE_MODE <= 1'b1;
      BUS_ASLEEP <= 1'b1;
      cyc(int'(IDLE_N) + 20);
      st_bit(LSF_ST_IDLE, 1'b0);
      BUS_ASLEEP <= 1'b0;
      cyc(20);
      st_bit(LSF_ST_IDLE, 1'b0);
      cyc(int'(IDLE_N));
      st_bit(LSF_ST_IDLE, 1'b1);
   endtask : t_idle
   task automatic t_abort();
      node.pulse(EV_BRK, 5'h00);
      node.pulse(EV_BRK, 5'h00);
      st_bit(LSF_ST_ABORT, 1'b1);
      node.pulse(EV_END, 5'h00);
      st_bit(LSF_ST_DONE, 1'b1);
      node.pulse(EV_BRK, 5'h00);
      st_bit(LSF_ST_ABORT, 1'b0);
      node.pulse(EV_END, 5'h00);
   endtask : t_abort
   task automatic t_frame();
      node.pulse(EV_START, 5'h00);
      st_bit(LSF_ST_DONE, 1'b0);
      node.pulse(EV_ID, 5'h00);
      st_bit(LSF_ST_DREQ, 1'b1);
      node.pulse(EV_END, 5'h00);
      st_bit(LSF_ST_DONE, 1'b1);
      DATA_ACKED <= 1'b1;
      cyc(4);
      DATA_ACKED <= 1'b0;
      cyc(4);
      st_bit(LSF_ST_DREQ, 1'b0);
   endtask : t_frame
   task automatic t_stop();
      wr(LSF_IDX_CONTROL, 32'h80);
      cyc(12);
      chk_pin(PROCESSING_STOPPED, 1'b1);
      rdm(LSF_IDX_MODE, 32'hffffffff, 32'h3);
      st_bit(LSF_ST_ABORT, 1'b1);
      rdm(LSF_IDX_CONTROL, 32'hffffffff, 32'h0);
      node.pulse(EV_BRK, 5'h00);
      chk_pin(PROCESSING_STOPPED, 1'b0);
      rdm(LSF_IDX_MODE, 32'hffffffff, 32'h1);
      node.pulse(EV_END, 5'h00);
   endtask : t_stop
   task automatic t_error();
      wr(LSF_IDX_IRQ_STAT, 32'hff);
      for (int k = 0; k < 5; k++) begin
         node.pulse(5'h00, 5'h01 << k);
         rdm(LSF_IDX_ERROR, 32'hffffffff, (32'h2 << k) - 32'h1);
      end
      wr(LSF_IDX_STATUS, 32'h0);
      st_bit(LSF_ST_ERR, 1'b1);
      rdm(LSF_IDX_IRQ_STAT, 32'h4, 32'h4);
      chk_pin(IRQ, 1'b0);
      wr(LSF_IDX_IRQ_MASK, 32'h4);
      cyc(2);
      chk_pin(IRQ, 1'b1);
      rdm(LSF_IDX_IRQ_MASK, 32'hffffffff, 32'h4);
      wr(LSF_IDX_IRQ_STAT, 32'h4);
      cyc(2);
      chk_pin(IRQ, 1'b0);
      wr(LSF_IDX_CONTROL, 32'h4);
      st_bit(LSF_ST_ERR, 1'b0);
      rdm(LSF_IDX_ERROR, 32'hffffffff, 32'h0);
   endtask : t_error
   task automatic t_int();
      CTRL_IRQ <= 1'b1;
      cyc(3);
      CTRL_IRQ <= 1'b0;
      cyc(15);
      st_bit(LSF_ST_INT, 1'b1);
      wr(LSF_IDX_CONTROL, 32'h8);
      st_bit(LSF_ST_INT, 1'b0);
   endtask : t_int
   task automatic t_wake();
      st_bit(LSF_ST_WAKE, 1'b0);
      WAKE_SENDING <= 1'b1;
      cyc(5);
      st_bit(LSF_ST_WAKE, 1'b1);
      WAKE_SENDING <= 1'b0;
      node.act(1'b1);
      node.act(1'b0);
      cyc(5);
      st_bit(LSF_ST_WAKE, 1'b0);
      node.pulse(EV_WAKE, 5'h00);
      st_bit(LSF_ST_WAKE, 1'b1);
   endtask : t_wake
   task automatic tally_and_finish();
      $display("checked %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : tally_and_finish
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      forever #12.5 SYS_CLK = ~SYS_CLK;
   end
   always @(posedge SYS_CLK) begin
      cycles++;
      if (cycles == 20000) begin
         err_total++;
         tally_and_finish();
      end
   end
   initial begin
      cyc(3);
      RST <= 1'b0;
      t_reset();
      t_wake();
      t_active();
      t_idle();
      t_abort();
      t_frame();
      t_stop();
      t_error();
      t_int();
      tally_and_finish();
   end
endmodule : lsf_status_regs_tb
bind lsf_status_regs lsf_status_assertions chk (.SYS_CLK, .RST, .HSEL, .HADDR, .HTRANS,
   .HWRITE, .HREADY, .HWDATA, .HRDATA, .HREADYOUT, .HRESP, .SLAVE_MODE, .SYNC_BREAK,
   .PROCESSING_STOPPED);
